// File: hdl/tbt_defines.svh
// register offsets, reset values, masks and timing counts for the 10BASE-T control block
`ifndef TBT_DEFINES_SVH
`define TBT_DEFINES_SVH
// register offsets on the management interface
`define TBT_OFS_TEN_CTL     5'h1A
`define TBT_OFS_TEST_EXT    5'h1B
// reset values: squelch field 100 at 11:9, scale bit 2 set
`define TBT_TEN_CTL_RST     16'h0804
`define TBT_TEST_EXT_RST    16'h0000
`define TBT_SQUELCH_RST     3'h4
// writable bits: bit 15 and status bit 4 dropped, counter and pull-up handled apart
`define TBT_TEN_CTL_WMASK   16'h7FEF
`define TBT_TEST_EXT_WMASK  16'h00F7
// pull-up enable position in the test register
`define TBT_PULLUP_BIT      3
// self-test counter ceiling
`define TBT_ERR_CNT_MAX     8'hFF
// management frame fields
`define TBT_PREAMBLE_LEN    6'h20
`define TBT_OP_READ         2'h2
`define TBT_OP_WRITE        2'h1
`define TBT_OP_BITS_LAST    5'h01
`define TBT_ADDR_BITS_LAST  5'h09
`define TBT_TA_BITS_LAST    5'h01
`define TBT_DATA_BITS_LAST  5'h0F
// pattern gap timing
`define TBT_CLK_MHZ         100
`define TBT_GAP_SHORT_US    10
`define TBT_GAP_LONG_US     15
`endif

// File: hdl/tbt_gap_timer.sv
// gap timer between common driver test sequences
`timescale 1ns/10ps
`default_nettype none
`include "tbt_defines.svh"
module tbt_gap_timer #(
  parameter int SHORT_CYC = `TBT_GAP_SHORT_US * `TBT_CLK_MHZ,
  parameter int LONG_CYC  = `TBT_GAP_LONG_US * `TBT_CLK_MHZ,
  parameter int CNT_W     = 11
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_start,
  input  wire logic i_long,
  // status
  output logic      o_done
);
  // two cycles of the gap are spent in the hand-off with the sequencer
  localparam logic [CNT_W-1:0] SHORT_LOAD = CNT_W'(SHORT_CYC - 2);
  localparam logic [CNT_W-1:0] LONG_LOAD  = CNT_W'(LONG_CYC - 2);
  logic [CNT_W-1:0] cnt_r;   // remaining cycles
  logic             busy_r;  // gap running

  // down counter, one done pulse at the end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        busy_r <= 1'b1;
        cnt_r  <= i_long ? LONG_LOAD : SHORT_LOAD;
      end else if (busy_r) begin
        if (cnt_r == '0) begin
          busy_r <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - CNT_W'(1);
        end
      end
    end
  end

  // helper: cycles since the last start
  int unsigned gap_len;
  logic        gap_long;
  always_ff @(posedge i_clk) begin
    if (i_start) begin
      gap_len  <= 1;
      gap_long <= i_long;
    end else begin
      gap_len <= gap_len + 1;
    end
  end
  property p_gap_len;
    @(posedge i_clk) disable iff (i_rst)
    o_done |-> gap_len == (gap_long ? LONG_CYC : SHORT_CYC);
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("pattern gap length wrong");
endmodule
`default_nettype wire

// File: hdl/tbt_pkg.sv
// types shared by the 10BASE-T control block
package tbt_pkg;
  // management frame phases, gray coded along the frame
  typedef enum logic [2:0] {
    MG_IDLE  = 3'h0,
    MG_START = 3'h1,
    MG_OP    = 3'h3,
    MG_ADDR  = 3'h2,
    MG_TA    = 3'h6,
    MG_DATA  = 3'h7
  } tbt_mgmt_st_t;
  // common driver pattern choice
  typedef enum logic [1:0] {
    PAT_DATA_EOP0   = 2'h0,
    PAT_DATA_EOP1   = 2'h1,
    PAT_LINK_PULSES = 2'h2,
    PAT_MANCH_ONES  = 2'h3
  } tbt_pat_sel_t;
  // 10BASE-T status and control layout
  typedef struct packed {
    logic       rsvd15;
    logic [2:0] rsvd14_12;
    logic [2:0] squelch;
    logic       loop_dis;
    logic       link_pulse_off;
    logic       force_link;
    logic       force_inv_pol;
    logic       polarity;
    logic       auto_pol_off;
    logic       scale_hi;
    logic       sqe_off;
    logic       jabber_off;
  } tbt_ten_ctl_t;
  // driver test and self-test extension layout
  typedef struct packed {
    logic [7:0] err_cnt;
    logic       rsvd7;
    logic       mii_clk_en;
    logic       cont;
    logic       pat_en;
    logic       pullup_en;
    logic       gap_sel;
    logic [1:0] pat_sel;
  } tbt_test_ext_t;
endpackage

// File: hdl/tbt_regs.sv
// 10BASE-T status/control and driver test registers behind the management interface
// Operation
// - squelch select at 11:9, resets 100
// - loopback disable ORed with basic control loopback
// - link pulse disable stops normal link pulses
// - force bit or pin gives good link
// - force bit inverts receive polarity
// - polarity latched high, read clears both copies
// - auto polarity runs unless disabled
// - scale bit with detect config sets silence
// - heartbeat only in 10 Mb half duplex
// - jabber disable bit acts in 10BASE-T
// - 8-bit errored nibble counter at 15:8
// - counter clears on restart, saturates at FFh
// - clock enable forces both MII clocks
// - continuous bit makes gapless self-test data
// - pattern enable bit starts driver patterns
// - pull-up bit drives pull-up, hard reset only
// - gap 15 us or 10 us per select
// - bit 15 reads zero, reserved written zero
// - two-bit select picks the test pattern
`timescale 1ns/10ps
`default_nettype none
`include "tbt_defines.svh"
module tbt_regs (
  // clock and resets
  input  wire logic           I_REF_CLK,
  input  wire logic           I_RST,
  input  wire logic           I_REG_RESET,
  // management pins
  input  wire logic           I_MDC,
  input  wire logic           I_MDIO,
  output logic                O_MDIO,
  output logic                O_MDIO_OE,
  input  wire logic [4:0]     I_PHY_ADDR,
  // link state from the transceiver core
  input  wire logic           I_EXTERNAL_FORCED_LINK_INPUT,
  input  wire logic           I_BASIC_CTL_LOOPBACK,
  input  wire logic           I_LINK_STATUS,
  input  wire logic           I_SPEED_100,
  input  wire logic           I_FULL_DUPLEX,
  input  wire logic           I_SIGNAL_DETECT_CFG_B10,
  input  wire logic           I_POLARITY_INVERTED,
  input  wire logic           I_PHY_STATUS_READ,
  // self-test and pattern status
  input  wire logic           I_SELFTEST_ACTIVE,
  input  wire logic           I_SELFTEST_RESTART,
  input  wire logic           I_SELFTEST_NIBBLE_ERR,
  input  wire logic           I_PATTERN_SEQ_DONE,
  // 10BASE-T controls
  output logic [2:0]          O_SQUELCH_ON_SEL,
  output logic                O_LOOPBACK_10_OFF,
  output logic                O_LINK_PULSE_TX_EN,
  output logic                O_LINK_GOOD_10,
  output logic                O_FORCE_INV_POLARITY,
  output logic                O_POLARITY_STATUS,
  output logic                O_AUTO_POLARITY_EN,
  output logic [1:0]          O_SILENCE_OFF_SEL,
  output logic                O_SQE_TEST_EN,
  output logic                O_JABBER_EN,
  // test controls
  output logic                O_MII_CLK_FORCE,
  output logic                O_SELFTEST_CONTINUOUS,
  output logic                O_PATTERN_EN,
  output tbt_pkg::tbt_pat_sel_t O_PATTERN_SEL,
  output logic                O_PATTERN_SEND,
  output logic                O_MGMT_DATA_PULLUP_EN
);
  import tbt_pkg::*;

  localparam int SYNC_W = 8;  // mdc, mdio, forced link, phy address

  logic [SYNC_W-1:0] sync1_r;     // first stage, read only by stage two
  logic [SYNC_W-1:0] sync2_r;     // settled pin levels
  logic [SYNC_W-1:0] pin_in;      // raw pins in synchroniser order
  logic              mdc_s;       // settled management clock
  logic              mdio_s;      // settled management data
  logic              ext_link_s;  // settled forced link pin
  logic [4:0]        phy_s;       // settled address straps
  logic              mdc_prev_r;  // for edge detection
  logic              mdc_rise;    // management clock rising edge

  tbt_mgmt_st_t      st_r;        // frame phase
  logic [4:0]        cnt_r;       // bit count within phase
  logic [5:0]        ones_r;      // preamble ones seen
  logic [15:0]       sh_r;        // incoming bits
  logic              op_rd_r;     // frame is a read
  logic              op_wr_r;     // frame is a write
  logic              hit_r;       // address matches this device
  logic [4:0]        reg_r;       // addressed register
  logic [9:0]        addr10;      // address bits as they complete
  logic              rd_fire;     // read frame addressed us
  logic              wr_fire;     // write frame finished
  logic [15:0]       wr_data;     // written word
  logic [15:0]       rd_word;     // word for the read shift
  logic [15:0]       rd_sh_r;     // outgoing bits

  tbt_ten_ctl_t      ten_r;       // stored 10BASE-T controls
  tbt_test_ext_t     test_r;      // stored test controls
  tbt_ten_ctl_t      ten_view;    // readback view
  tbt_test_ext_t     test_view;   // readback view
  logic              pol_r;       // latched inverted polarity
  logic              pol_clr;     // read of either copy
  logic [7:0]        err_cnt_r;   // errored nibble count
  logic              pullup_r;    // hard reset only
  logic              gap_wait_r;  // pattern gap running
  logic              gap_start;   // sequence finished, gap begins
  logic              gap_done;    // gap over

  // two flops on every pin before use; one vector keeps every index in range
  assign pin_in = {I_PHY_ADDR, I_EXTERNAL_FORCED_LINK_INPUT, I_MDIO, I_MDC};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate
  assign mdc_s      = sync2_r[0];
  assign mdio_s     = sync2_r[1];
  assign ext_link_s = sync2_r[2];
  assign phy_s      = sync2_r[7:3];

  // management clock edge, found on the settled copy
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      mdc_prev_r <= 1'b0;
    end else begin
      mdc_prev_r <= mdc_s;
    end
  end
  assign mdc_rise = mdc_s & ~mdc_prev_r;

  // frame decode strobes
  assign addr10  = {sh_r[8:0], mdio_s};
  assign rd_fire = mdc_rise && st_r == MG_ADDR && cnt_r == `TBT_ADDR_BITS_LAST && op_rd_r && addr10[9:5] == phy_s;
  assign wr_fire = mdc_rise && st_r == MG_DATA && cnt_r == `TBT_DATA_BITS_LAST && op_wr_r && hit_r;
  assign wr_data = {sh_r[14:0], mdio_s};

  // frame phases: preamble, start, opcode, addresses, turnaround, data
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      st_r    <= MG_IDLE;
      cnt_r   <= 5'h00;
      ones_r  <= 6'h00;
      sh_r    <= 16'h0000;
      op_rd_r <= 1'b0;
      op_wr_r <= 1'b0;
      hit_r   <= 1'b0;
      reg_r   <= 5'h00;
    end else if (mdc_rise) begin
      unique case (st_r)
        MG_IDLE: begin
          if (mdio_s) begin
            if (ones_r != `TBT_PREAMBLE_LEN) ones_r <= ones_r + 6'h01;
          end else begin
            // a zero ends the preamble; too few ones drops the frame
            if (ones_r == `TBT_PREAMBLE_LEN) st_r <= MG_START;
            ones_r <= 6'h00;
          end
        end
        MG_START: begin
          st_r  <= mdio_s ? MG_OP : MG_IDLE;
          cnt_r <= 5'h00;
        end
        MG_OP: begin
          sh_r  <= {sh_r[14:0], mdio_s};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == `TBT_OP_BITS_LAST) begin
            op_rd_r <= {sh_r[0], mdio_s} == `TBT_OP_READ;
            op_wr_r <= {sh_r[0], mdio_s} == `TBT_OP_WRITE;
            st_r    <= MG_ADDR;
            cnt_r   <= 5'h00;
          end
        end
        MG_ADDR: begin
          sh_r  <= {sh_r[14:0], mdio_s};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == `TBT_ADDR_BITS_LAST) begin
            hit_r <= addr10[9:5] == phy_s;
            reg_r <= addr10[4:0];
            st_r  <= MG_TA;
            cnt_r <= 5'h00;
          end
        end
        MG_TA: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == `TBT_TA_BITS_LAST) begin
            st_r  <= MG_DATA;
            cnt_r <= 5'h00;
          end
        end
        MG_DATA: begin
          sh_r  <= {sh_r[14:0], mdio_s};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == `TBT_DATA_BITS_LAST) begin
            st_r  <= MG_IDLE;
            cnt_r <= 5'h00;
          end
        end
        default: st_r <= MG_IDLE;
      endcase
    end
  end

  // readback mux; unmapped registers read zero
  always_comb begin
    ten_view           = ten_r;
    ten_view.rsvd15    = 1'b0;
    ten_view.polarity  = pol_r;
    test_view          = test_r;
    test_view.err_cnt  = err_cnt_r;
    test_view.pullup_en = pullup_r;
    rd_word            = 16'h0000;
    if (addr10[4:0] == `TBT_OFS_TEN_CTL) begin
      rd_word = ten_view;
    end else if (addr10[4:0] == `TBT_OFS_TEST_EXT) begin
      rd_word = test_view;
    end
  end

  // read drive: zero in the second turnaround bit, data after each rising edge
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_MDIO    <= 1'b0;
      O_MDIO_OE <= 1'b0;
      rd_sh_r   <= 16'h0000;
    end else if (rd_fire) begin
      rd_sh_r <= rd_word;
    end else if (mdc_rise && op_rd_r && hit_r) begin
      if (st_r == MG_TA && cnt_r == 5'h00) begin
        O_MDIO_OE <= 1'b1;
        O_MDIO    <= 1'b0;
      end else if (st_r == MG_DATA && cnt_r == `TBT_DATA_BITS_LAST) begin
        O_MDIO_OE <= 1'b0;
        O_MDIO    <= 1'b0;
      end else if (st_r == MG_TA || st_r == MG_DATA) begin
        O_MDIO  <= rd_sh_r[15];
        rd_sh_r <= {rd_sh_r[14:0], 1'b0};
      end
    end
  end

  // 10BASE-T register; bit 15 and the status bit are not stored
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || I_REG_RESET) begin
      ten_r <= `TBT_TEN_CTL_RST;
    end else if (wr_fire && reg_r == `TBT_OFS_TEN_CTL) begin
      ten_r <= wr_data & `TBT_TEN_CTL_WMASK;
    end
  end

  // test register; counter and pull-up live apart
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || I_REG_RESET) begin
      test_r <= `TBT_TEST_EXT_RST;
    end else if (wr_fire && reg_r == `TBT_OFS_TEST_EXT) begin
      test_r <= wr_data & `TBT_TEST_EXT_WMASK;
    end
  end

  // pull-up survives register resets so the bus stays defined
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pullup_r <= 1'b0;
    end else if (wr_fire && reg_r == `TBT_OFS_TEST_EXT) begin
      pullup_r <= wr_data[`TBT_PULLUP_BIT];
    end
  end

  // polarity latch: a new detection beats a clearing read
  assign pol_clr = I_PHY_STATUS_READ || (rd_fire && addr10[4:0] == `TBT_OFS_TEN_CTL);
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || I_REG_RESET) begin
      pol_r <= 1'b0;
    end else if (I_POLARITY_INVERTED) begin
      pol_r <= 1'b1;
    end else if (pol_clr) begin
      pol_r <= 1'b0;
    end
  end

  // errored nibble counter, sticks at the top
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || I_REG_RESET || I_SELFTEST_RESTART) begin
      err_cnt_r <= 8'h00;
    end else if (I_SELFTEST_NIBBLE_ERR && err_cnt_r != `TBT_ERR_CNT_MAX) begin
      err_cnt_r <= err_cnt_r + 8'h01;
    end
  end

  // registered control outputs
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_SQUELCH_ON_SEL      <= `TBT_SQUELCH_RST;
      O_LOOPBACK_10_OFF     <= 1'b0;
      O_LINK_PULSE_TX_EN    <= 1'b0;
      O_LINK_GOOD_10        <= 1'b0;
      O_FORCE_INV_POLARITY  <= 1'b0;
      O_POLARITY_STATUS     <= 1'b0;
      O_AUTO_POLARITY_EN    <= 1'b0;
      O_SILENCE_OFF_SEL     <= 2'h0;
      O_SQE_TEST_EN         <= 1'b0;
      O_JABBER_EN           <= 1'b0;
      O_MII_CLK_FORCE       <= 1'b0;
      O_SELFTEST_CONTINUOUS <= 1'b0;
      O_PATTERN_EN          <= 1'b0;
      O_PATTERN_SEL         <= PAT_DATA_EOP0;
      O_MGMT_DATA_PULLUP_EN <= 1'b0;
    end else begin
      O_SQUELCH_ON_SEL      <= ten_r.squelch;
      O_LOOPBACK_10_OFF     <= ten_r.loop_dis | I_BASIC_CTL_LOOPBACK;
      O_LINK_PULSE_TX_EN    <= ~(ten_r.link_pulse_off | ext_link_s);
      O_LINK_GOOD_10        <= ten_r.force_link | ext_link_s | I_LINK_STATUS;
      O_FORCE_INV_POLARITY  <= ten_r.force_inv_pol;
      O_POLARITY_STATUS     <= pol_r;
      O_AUTO_POLARITY_EN    <= ~ten_r.auto_pol_off;
      O_SILENCE_OFF_SEL     <= {ten_r.scale_hi, I_SIGNAL_DETECT_CFG_B10};
      // heartbeat forced off at 100 Mb and in full duplex
      O_SQE_TEST_EN         <= ~ten_r.sqe_off & ~I_SPEED_100 & ~I_FULL_DUPLEX;
      O_JABBER_EN           <= ~ten_r.jabber_off & ~I_SPEED_100;
      O_MII_CLK_FORCE       <= test_r.mii_clk_en;
      // the host must clear the jabber guard first at 10 Mb; not enforced here
      O_SELFTEST_CONTINUOUS <= test_r.cont & I_SELFTEST_ACTIVE;
      O_PATTERN_EN          <= test_r.pat_en;
      O_PATTERN_SEL         <= tbt_pat_sel_t'(test_r.pat_sel);
      O_MGMT_DATA_PULLUP_EN <= pullup_r;
    end
  end

  // pattern sequencer: send, then wait out the gap
  assign gap_start = O_PATTERN_SEND && I_PATTERN_SEQ_DONE && test_r.pat_en;
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST || !test_r.pat_en) begin
      O_PATTERN_SEND <= 1'b0;
      gap_wait_r     <= 1'b0;
    end else if (gap_start) begin
      O_PATTERN_SEND <= 1'b0;
      gap_wait_r     <= 1'b1;
    end else if (gap_wait_r) begin
      if (gap_done) begin
        gap_wait_r     <= 1'b0;
        O_PATTERN_SEND <= 1'b1;
      end
    end else begin
      O_PATTERN_SEND <= 1'b1;
    end
  end

  tbt_gap_timer u_gap (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_start (gap_start),
    .i_long  (test_r.gap_sel),
    .o_done  (gap_done)
  );

  // checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  property p_squelch_wr;
    (wr_fire && reg_r == `TBT_OFS_TEN_CTL && !I_REG_RESET) |=> ##1 O_SQUELCH_ON_SEL == $past(wr_data[11:9], 2);
  endproperty
  a_squelch_wr: assert property (p_squelch_wr) else $error("squelch select not applied");
  property p_loop_or;
    I_BASIC_CTL_LOOPBACK |=> O_LOOPBACK_10_OFF;
  endproperty
  a_loop_or: assert property (p_loop_or) else $error("loopback disable not ORed");
  property p_nlp_off;
    ten_r.link_pulse_off |=> !O_LINK_PULSE_TX_EN;
  endproperty
  a_nlp_off: assert property (p_nlp_off) else $error("link pulses not stopped");
  property p_force_link;
    (ten_r.force_link || ext_link_s) |=> O_LINK_GOOD_10;
  endproperty
  a_force_link: assert property (p_force_link) else $error("forced link not reported");
  property p_pol_set;
    I_POLARITY_INVERTED |=> pol_r ##1 O_POLARITY_STATUS;
  endproperty
  a_pol_set: assert property (p_pol_set) else $error("polarity detection lost");
  property p_pol_clr;
    (pol_clr && !I_POLARITY_INVERTED) |=> !pol_r;
  endproperty
  a_pol_clr: assert property (p_pol_clr) else $error("polarity not cleared by read");
  property p_sqe_off;
    (I_SPEED_100 || I_FULL_DUPLEX) |=> !O_SQE_TEST_EN;
  endproperty
  a_sqe_off: assert property (p_sqe_off) else $error("heartbeat on outside 10 Mb half duplex");
  property p_jabber;
    (ten_r.jabber_off && !I_REG_RESET) |=> !O_JABBER_EN;
  endproperty
  a_jabber: assert property (p_jabber) else $error("jabber not disabled");
  property p_cnt_sat;
    (err_cnt_r == `TBT_ERR_CNT_MAX && !I_SELFTEST_RESTART && !I_REG_RESET) |=> err_cnt_r == `TBT_ERR_CNT_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("error counter wrapped");
  property p_cnt_clr;
    I_SELFTEST_RESTART |=> err_cnt_r == 8'h00;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("error counter not cleared");
  property p_read_bit15;
    rd_fire |=> !rd_sh_r[15] || reg_r != `TBT_OFS_TEN_CTL;
  endproperty
  a_read_bit15: assert property (p_read_bit15) else $error("bit 15 read as one");

  c_read: cover property (rd_fire);
  c_write: cover property (wr_fire);
  c_saturate: cover property (err_cnt_r == `TBT_ERR_CNT_MAX && I_SELFTEST_NIBBLE_ERR);
  c_gap: cover property (gap_start ##[1:1000] gap_done);
endmodule
`default_nettype wire

// File: test/tbt_mdio_host.sv
// management host model for the serial register link
`timescale 1ns/10ps
`default_nettype none
module tbt_mdio_host (
  // management pins
  output logic      o_mdc,
  output logic      o_line,
  input  wire logic i_dout,
  input  wire logic i_oe
);
  logic hen = 1'h0; // host drives the line
  logic hb  = 1'h1; // host bit
  // a released line shows the inverse, never a stale copy
  assign o_line = i_oe ? i_dout : (hen ? hb : ~hb);
  initial o_mdc = 1'h0;
  // one frame at 125 ns a bit; clock stands still between frames
  task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rq);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'h1, rd ? 2'h2 : 2'h1, 5'h01, ra, 2'h2, wd};
    for (int k = 63; k >= 0; k--) begin
      hen = !(rd && k < 18); // turnaround and data left to the device
      hb = f[k];
      #62.5;
      if (k < 16) rq[k] = o_line;
      o_mdc = 1'h1;
      #62.5;
      o_mdc = 1'h0;
    end
    hen = 1'h0;
  endtask
endmodule
`default_nettype wire

// File: test/tbt_regs_test.sv
// self-checking bench for the 10BASE-T control registers
`timescale 1ns/10ps
`default_nettype none
module tbt_regs_test;
  import tbt_pkg::*;
  // signals carry the port names so the instance binds by name
  logic I_REF_CLK = 0, I_RST = 1, I_REG_RESET = 0, I_EXTERNAL_FORCED_LINK_INPUT = 0, I_BASIC_CTL_LOOPBACK = 0;
  logic I_LINK_STATUS = 0, I_SPEED_100 = 0, I_FULL_DUPLEX = 0, I_SIGNAL_DETECT_CFG_B10 = 0, I_POLARITY_INVERTED = 0;
  logic I_PHY_STATUS_READ = 0, I_SELFTEST_ACTIVE = 1, I_SELFTEST_RESTART = 0, I_SELFTEST_NIBBLE_ERR = 0;
  logic I_PATTERN_SEQ_DONE = 0;
  logic [4:0] I_PHY_ADDR = 5'h01; // strap matching the host frames, moved away once in t_reset
  wire I_MDC, I_MDIO;
  logic O_MDIO, O_MDIO_OE, O_LOOPBACK_10_OFF, O_LINK_PULSE_TX_EN, O_LINK_GOOD_10, O_FORCE_INV_POLARITY;
  logic O_POLARITY_STATUS, O_AUTO_POLARITY_EN, O_SQE_TEST_EN, O_JABBER_EN, O_MII_CLK_FORCE;
  logic O_SELFTEST_CONTINUOUS, O_PATTERN_EN, O_PATTERN_SEND, O_MGMT_DATA_PULLUP_EN;
  logic [2:0] O_SQUELCH_ON_SEL;
  logic [1:0] O_SILENCE_OFF_SEL;
  tbt_pat_sel_t O_PATTERN_SEL;
  logic [15:0] q; // last word read
  int miscompares = 0, n_tests = 0;
  // 10BASE-T control outputs side by side
  wire [11:0] ctl_o = {O_SQUELCH_ON_SEL, O_LOOPBACK_10_OFF, O_LINK_PULSE_TX_EN, O_LINK_GOOD_10,
    O_FORCE_INV_POLARITY, O_AUTO_POLARITY_EN, O_SILENCE_OFF_SEL, O_SQE_TEST_EN, O_JABBER_EN};
  tbt_regs u_tbt_regs (.*);
  tbt_mdio_host u_tbt_mdio_host (.o_mdc(I_MDC), .o_line(I_MDIO), .i_dout(O_MDIO), .i_oe(O_MDIO_OE));
  always #5 I_REF_CLK = ~I_REF_CLK;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge I_REF_CLK);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
    cyc(1);
  endtask
  // frames leave room for the synced update to land
  task automatic rd(input logic [4:0] a);
    u_tbt_mdio_host.xfer(1'h1, a, 16'h0000, q);
    cyc(4);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_tbt_mdio_host.xfer(1'h0, a, d, q);
    cyc(4);
  endtask
  task automatic results;
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset;
    rd(5'h1A);
    chk(q, 16'h0804);
    I_PHY_ADDR = 5'h02; // the write below no longer addresses us
    wr(5'h1A, 16'h0000);
    I_PHY_ADDR = 5'h01;
    rd(5'h1A);
    chk(q, 16'h0804);
    rd(5'h1C);
    chk(q, 16'h0000);
  endtask
  task automatic t_ctl;
    wr(5'h1A, 16'h8FFF); // bit 15 set, reserved 14:12 kept zero
    rd(5'h1A);
    chk(q, 16'h0FEF);
    chk(16'(ctl_o), 16'h0F68);
    I_BASIC_CTL_LOOPBACK = 1;
    I_SIGNAL_DETECT_CFG_B10 = 1;
    wr(5'h1A, 16'h0000);
    chk(16'(ctl_o), 16'h0197);
    I_LINK_STATUS = 1;
    cyc(2);
    chk(16'(O_LINK_GOOD_10), 16'h0001);
    I_LINK_STATUS = 0;
    I_EXTERNAL_FORCED_LINK_INPUT = 1;
    I_FULL_DUPLEX = 1;
    cyc(6);
    chk(16'(ctl_o), 16'h0155);
    I_SPEED_100 = 1; // 100 Mb from here on, so continuous self-test needs no jabber-off
    cyc(2);
    chk(16'(ctl_o), 16'h0154);
  endtask
  task automatic t_pol;
    pulse(I_POLARITY_INVERTED);
    chk(16'(O_POLARITY_STATUS), 16'h0001);
    rd(5'h1A);
    chk(q, 16'h0010);
    chk(16'(O_POLARITY_STATUS), 16'h0000);
    pulse(I_POLARITY_INVERTED);
    pulse(I_PHY_STATUS_READ);
    rd(5'h1A);
    chk(q, 16'h0000);
  endtask
  task automatic t_cnt;
    repeat (3) pulse(I_SELFTEST_NIBBLE_ERR);
    rd(5'h1B);
    chk(q, 16'h0300);
    repeat (300) pulse(I_SELFTEST_NIBBLE_ERR);
    rd(5'h1B);
    chk(q, 16'hFF00);
    pulse(I_SELFTEST_RESTART);
    rd(5'h1B);
    chk(q, 16'h0000);
  endtask
  task automatic t_test;
    wr(5'h1B, 16'hFF7F);
    rd(5'h1B);
    chk(q, 16'h007F);
    chk(16'({O_MII_CLK_FORCE, O_SELFTEST_CONTINUOUS, O_PATTERN_EN, O_MGMT_DATA_PULLUP_EN, O_PATTERN_SEL}),
      16'h003F);
    I_SELFTEST_ACTIVE = 0;
    cyc(2);
    chk(16'(O_SELFTEST_CONTINUOUS), 16'h0000);
    I_SELFTEST_ACTIVE = 1;
    pulse(I_REG_RESET);
    rd(5'h1B);
    chk(q, 16'h0008);
    for (int p = 0; p < 4; p++) begin
      wr(5'h1B, 16'h0010 | 16'(p)); // pull-up left off again
      chk(16'(O_PATTERN_SEL), 16'(p));
    end
    chk(16'(O_MGMT_DATA_PULLUP_EN), 16'h0000);
  endtask
  // low cycles counted at each falling edge, wherever the gap starts
  task automatic t_gap(input logic g, input int n);
    int c;
    c = 0;
    wr(5'h1B, {11'h000, 2'h2, g, 2'h0});
    chk(16'(O_PATTERN_SEND), 16'h0001);
    I_PATTERN_SEQ_DONE = 1;
    cyc(1);
    I_PATTERN_SEQ_DONE = 0;
    repeat (2000) begin
      if (O_PATTERN_SEND === 1'h0) c++;
      cyc(1);
    end
    chk(16'(c), 16'(n));
  endtask
  initial begin
    cyc(4);
    I_RST = 0;
    t_reset;
    t_ctl;
    t_pol;
    t_cnt;
    t_test;
    t_gap(1'h0, 1000);
    t_gap(1'h1, 1500);
    wr(5'h1B, 16'h0000);
    chk(16'(O_PATTERN_SEND), 16'h0000);
    results;
  end
  // traffic takes about 220 us; reaching 500 us, over twice that, means a hang
  initial begin
    #500000;
    miscompares++;
    results;
  end
endmodule
`default_nettype wire
